/* design/pfs_port.sv */
// PCM highway port: bit and frame timing, lock, offsets, serial lanes.
// Assumes bit clock, frame pulse and receive lines are asynchronous pins;
// configuration inputs come from logic on CLK_I and are steady in use.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_cfg.svh"

module pfs_port #(
  parameter int FIFO_DEPTH = `PFS_FIFO_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire pfs_pkg::pfs_mode_t MODE_I,
  input wire logic DOUBLE_CLOCK_I,
  input wire logic [`PFS_OFS_W-1:0] INPUT_FRAME_OFFSET_I,
  input wire logic [`PFS_OFS_W-1:0] OUTPUT_FRAME_OFFSET_I,
  input wire logic [`PFS_OFS_W-1:0] THIRD_FRAME_OFFSET_I,
  input wire logic [`PFS_PORTS-1:0] TX_ENABLE_I,
  input wire pfs_pkg::pfs_lanes_t TX_DATA_I,
  input wire logic PCM_BIT_CLOCK_I,
  input wire logic PCM_FRAME_PULSE_I,
  input wire logic [`PFS_PORTS-1:0] PCM_RX_LINE_I,
  input wire logic RX_READY_I,
  output logic [`PFS_PORTS-1:0] PCM_TX_LINE_O,
  output logic [`PFS_PORTS-1:0] PCM_TX_LINE_OE_O,
  output logic [`PFS_PORTS-1:0] TX_DRIVE_INDICATOR_O,
  output logic [`PFS_SLOT_W-1:0] TX_SLOT_O,
  output logic TX_LOAD_O,
  output pfs_pkg::pfs_rx_word_t RX_DATA_O,
  output logic RX_VALID_O,
  output logic RX_OVERRUN_O,
  output logic FRAME_LOCK_FLAG_O,
  output logic GCI_BIT_CLOCK_OUT_O,
  output logic GCI_FRAME_SYNC_OUT_O
);
  import pfs_pkg::*;

  localparam int RXW = $bits(pfs_rx_word_t);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic clk_m;
    logic clk_s;
    logic clk_d;
    logic fp_m;
    logic fp_s;
    logic fp_last;
    logic [`PFS_PORTS-1:0] rx_m;
    logic [`PFS_PORTS-1:0] rx_s;
    logic half;
    logic bit_tick;
    logic frame_edge;
    logic rx_run;
    logic [`PFS_OFS_W-1:0] rx_skip;
    logic [2:0] rx_bit;
    logic [`PFS_SLOT_W-1:0] rx_slot;
    pfs_lanes_t rx_sh;
    logic push;
    pfs_rx_word_t push_word;
    logic overrun;
    logic tx_run;
    logic [`PFS_OFS_W-1:0] tx_skip;
    logic [2:0] tx_bit;
    logic [`PFS_SLOT_W-1:0] tx_slot;
    pfs_lanes_t tx_sh;
    logic [`PFS_PORTS-1:0] tx_line;
    logic [`PFS_PORTS-1:0] tx_oe;
    logic [`PFS_PORTS-1:0] tx_ind;
    logic tx_load;
    logic [2:0] gdiv;
    logic gclk;
    logic fs_pend;
    logic [`PFS_OFS_W-1:0] fs_skip;
    logic gfs;
  } pfs_port_state_t;

  pfs_port_state_t s;
  pfs_port_state_t next_s;

  pfs_frame_if frm ();
  pfs_stream_if #(.W(RXW)) wr ();
  pfs_stream_if #(.W(RXW)) rd ();

  logic rise;
  logic any_edge;
  logic fp_rise;
  logic tick;
  logic frame;
  logic [`PFS_PORTS-1:0] act;
  logic [`PFS_OFS_W-1:0] skip;
  logic [2:0] bit_no;
  logic [`PFS_SLOT_W-1:0] slot_no;
  logic [1:0] gsel;
  logic [2:0] gmask;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    skip = '0;
    bit_no = '0;
    slot_no = '0;

    // Two flops on every asynchronous pin before anything looks at it
    next_s.clk_m = PCM_BIT_CLOCK_I;
    next_s.clk_s = s.clk_m;
    next_s.clk_d = s.clk_s;
    next_s.fp_m = PCM_FRAME_PULSE_I;
    next_s.fp_s = s.fp_m;
    next_s.rx_m = PCM_RX_LINE_I;
    next_s.rx_s = s.rx_m;

    case (MODE_I)
      PFS_MODE_0: act = `PFS_ACT_MODE0;
      PFS_MODE_1: act = `PFS_ACT_MODE1;
      default: act = `PFS_ACT_MODE2;
    endcase

    rise = s.clk_s & ~s.clk_d;
    any_edge = s.clk_s ^ s.clk_d;
    fp_rise = s.fp_s & ~s.fp_last;
    // Double clocking: every second rising edge is a bit, and the
    // frame pulse edge realigns the phase so a bad start cannot persist
    tick = rise & (fp_rise | ~DOUBLE_CLOCK_I | s.half);
    frame = tick & fp_rise;
    if (rise) begin
      next_s.fp_last = s.fp_s;
      next_s.half = ~tick;
    end
    next_s.bit_tick = tick;
    next_s.frame_edge = frame;
    next_s.tx_load = 1'b0;

    // A pending word leaves once the FIFO takes it
    if (s.push && wr.ready) begin
      next_s.push = 1'b0;
    end

    if (tick) begin
      // ****************************************
      // Receive lanes
      // ****************************************
      skip = frame ? INPUT_FRAME_OFFSET_I : s.rx_skip;
      bit_no = frame ? 3'h0 : s.rx_bit;
      slot_no = frame ? '0 : s.rx_slot;
      next_s.rx_run = frame | s.rx_run;
      if (frame) begin
        next_s.rx_bit = 3'h0;
        next_s.rx_slot = '0;
      end
      if (next_s.rx_run && skip != '0) begin
        next_s.rx_skip = skip - 1'b1;
      end else if (next_s.rx_run) begin
        next_s.rx_skip = '0;
        for (int p = 0; p < `PFS_PORTS; p++) begin
          next_s.rx_sh[p] = {s.rx_sh[p][6:0], s.rx_s[p] & act[p]};
        end
        next_s.rx_bit = bit_no + 1'b1;
        if (bit_no == 3'h7) begin
          next_s.rx_slot = slot_no + 1'b1;
          // A word still waiting when the next one lands is lost
          if (s.push && !wr.ready) begin
            next_s.overrun = 1'b1;
          end
          next_s.push = 1'b1;
          next_s.push_word.slot = slot_no;
          next_s.push_word.lanes = next_s.rx_sh;
        end
      end

      // ****************************************
      // Transmit lanes
      // ****************************************
      skip = frame ? OUTPUT_FRAME_OFFSET_I : s.tx_skip;
      bit_no = frame ? 3'h0 : s.tx_bit;
      slot_no = frame ? '0 : s.tx_slot;
      next_s.tx_run = frame | s.tx_run;
      if (frame) begin
        next_s.tx_bit = 3'h0;
        next_s.tx_slot = '0;
      end
      next_s.tx_oe = '0;
      if (next_s.tx_run && skip != '0) begin
        next_s.tx_skip = skip - 1'b1;
      end else if (next_s.tx_run) begin
        next_s.tx_skip = '0;
        if (bit_no == 3'h0) begin
          next_s.tx_load = 1'b1;
          for (int p = 0; p < `PFS_PORTS; p++) begin
            next_s.tx_line[p] = TX_DATA_I[p][7];
            next_s.tx_sh[p] = {TX_DATA_I[p][6:0], 1'b0};
          end
        end else begin
          for (int p = 0; p < `PFS_PORTS; p++) begin
            next_s.tx_line[p] = s.tx_sh[p][7];
            next_s.tx_sh[p] = {s.tx_sh[p][6:0], 1'b0};
          end
        end
        next_s.tx_bit = bit_no + 1'b1;
        if (bit_no == 3'h7) begin
          next_s.tx_slot = slot_no + 1'b1;
        end
        next_s.tx_oe = act & TX_ENABLE_I & {`PFS_PORTS{frm.locked}};
      end

      // ****************************************
      // GCI frame sync, one bit long
      // ****************************************
      skip = frame ? THIRD_FRAME_OFFSET_I : s.fs_skip;
      next_s.gfs = 1'b0;
      if (frame || s.fs_pend) begin
        if (skip == '0) begin
          next_s.gfs = 1'b1;
          next_s.fs_pend = 1'b0;
        end else begin
          next_s.fs_skip = skip - 1'b1;
          next_s.fs_pend = 1'b1;
        end
      end
    end

    // Losing lock releases the lines at once, not at the next bit
    if (!frm.locked) begin
      next_s.tx_oe = '0;
    end
    // A lane dropped by a mode change is released at once as well
    next_s.tx_oe = next_s.tx_oe & act;
    next_s.tx_ind = ~next_s.tx_oe;

    // ****************************************
    // GCI bit clock
    // ****************************************
    // Output rate is the bit clock divided by 1, 2 or 4; a bit clock
    // slower than the GCI rate is passed through, it cannot be multiplied
    // Mode 11 divides as mode 2 does
    gsel = (MODE_I == PFS_MODE_0) ? 2'h0 : ((MODE_I == PFS_MODE_1) ? 2'h1 : 2'h2);
    gsel = gsel + 2'(DOUBLE_CLOCK_I);
    gmask = (gsel == 2'h3) ? `PFS_GDIV_MASK4 : `PFS_GDIV_MASK2;
    if (frame) begin
      next_s.gdiv = '0;
    end else if (any_edge) begin
      next_s.gdiv = s.gdiv + 1'b1;
    end
    if (gsel <= 2'h1) begin
      next_s.gclk = s.clk_s;
    end else if (any_edge && (s.gdiv & gmask) == gmask) begin
      next_s.gclk = ~s.gclk;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s <= '0;
      s.tx_ind <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  assign frm.bit_tick = s.bit_tick;
  assign frm.frame_edge = s.frame_edge;
  assign wr.valid = s.push;
  assign wr.data = s.push_word;
  assign rd.ready = RX_READY_I;

  pfs_sync #(
    .CNT_W(`PFS_CNT_W)
  ) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .frm(frm)
  );

  pfs_fifo #(
    .W(RXW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .wr(wr),
    .rd(rd)
  );

  // ****************************************
  // Outputs, all from flops
  // ****************************************
  assign PCM_TX_LINE_O = s.tx_line;
  assign PCM_TX_LINE_OE_O = s.tx_oe;
  assign TX_DRIVE_INDICATOR_O = s.tx_ind;
  assign TX_SLOT_O = s.tx_slot;
  assign TX_LOAD_O = s.tx_load;
  assign RX_DATA_O = rd.data;
  assign RX_VALID_O = rd.valid;
  assign RX_OVERRUN_O = s.overrun;
  assign FRAME_LOCK_FLAG_O = frm.locked;
  assign GCI_BIT_CLOCK_OUT_O = s.gclk;
  assign GCI_FRAME_SYNC_OUT_O = s.gfs;
endmodule // pfs_port

`default_nettype wire

/* design/pfs_cfg.svh */
// Constants of the PCM frame sync port: widths, depths and port masks.
// Assumes it is included by its bare name, by pfs_pkg and by the files that use its macros.
// Functional notes
// - Three configurations exist: mode 0 drives four ports up to 2048 kb/s, mode 1 two ports up to 4096 kb/s, mode 2 one port up to 8192 kb/s.
// - The rising edge of the frame pulse marks the first bit of slot 0 of both frames when no offset is set.
// - After reset, lock is declared only after three consecutive frame pulses arrive with a correct, consistent spacing.
// - The pulse interval measured when the search starts is stored, and lock is dropped when a pulse misses it.
// - The frame lock flag reads 1 while locked and 0 once lock is lost.
// - Three offsets each hold a count of bit times by which the slot structure is shifted from the frame pulse.
// - The port stays in its reset state for as long as the reset input is high.
// - Each tristate indicator is low exactly while its transmit line carries valid data.
// - The GCI bit clock and frame sync outputs are derived from the incoming bit clock and frame pulse.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define PFS_PORTS 4
`define PFS_OFS_W 10
`define PFS_CNT_W 11
`define PFS_SLOT_W 7
`define PFS_FIFO_DEPTH 8

// ****************************************
// Active lane masks per mode and GCI clock divider masks
// ****************************************
`define PFS_ACT_MODE0 4'hf
`define PFS_ACT_MODE1 4'h3
`define PFS_ACT_MODE2 4'h1
`define PFS_GDIV_MASK2 3'h1
`define PFS_GDIV_MASK4 3'h3

`endif

/* design/pfs_pkg.sv */
// Types shared by the PCM frame sync port and its helpers.
// Assumes pfs_cfg.svh is on the include path.
package pfs_pkg;
  `include "pfs_cfg.svh"

  typedef enum logic [1:0] {
    PFS_MODE_0 = 2'b00,
    PFS_MODE_1 = 2'b01,
    PFS_MODE_2 = 2'b10
  } pfs_mode_t;

  typedef enum logic [1:0] {
    PFS_SEARCH  = 2'b00,
    PFS_MEASURE = 2'b01,
    PFS_CONFIRM = 2'b10,
    PFS_LOCKED  = 2'b11
  } pfs_sync_st_t;

  typedef logic [`PFS_PORTS-1:0][7:0] pfs_lanes_t;

  typedef struct packed {
    logic [`PFS_SLOT_W-1:0] slot;
    pfs_lanes_t lanes;
  } pfs_rx_word_t;
endpackage

/* design/pfs_if.sv */
// Carriers between the port and its helpers: frame timing and a word stream.
// Assumes one clock domain; all members except the stream ready are driven from registers.
`timescale 1ns/1ns
`default_nettype none

interface pfs_frame_if;
  logic bit_tick;
  logic frame_edge;
  logic locked;
  modport tracker (input bit_tick, input frame_edge, output locked);
  modport port (output bit_tick, output frame_edge, input locked);
endinterface // pfs_frame_if

interface pfs_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // pfs_stream_if

`default_nettype wire

/* design/pfs_sync.sv */
// Frame pulse tracker: measures the pulse interval and keeps lock.
// Assumes bit_tick and frame_edge are one-cycle pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_cfg.svh"

module pfs_sync #(
  parameter int CNT_W = `PFS_CNT_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  pfs_frame_if.tracker frm
);
  import pfs_pkg::*;

  typedef struct packed {
    pfs_sync_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] interval;
    logic locked;
  } pfs_sync_state_t;

  pfs_sync_state_t s;
  pfs_sync_state_t next_s;

  always_comb begin
    next_s = s;
    if (frm.bit_tick) begin
      if (s.cnt != '1) begin
        next_s.cnt = s.cnt + 1'b1;
      end
      if (frm.frame_edge) begin
        next_s.cnt = '0;
        case (s.st)
          PFS_SEARCH: begin
            next_s.st = PFS_MEASURE;
          end
          PFS_MEASURE: begin
            next_s.interval = s.cnt;
            next_s.st = PFS_CONFIRM;
          end
          PFS_CONFIRM, PFS_LOCKED: begin
            // A wrong spacing restarts the search from this pulse
            if (s.cnt == s.interval) begin
              next_s.st = PFS_LOCKED;
            end else begin
              next_s.st = PFS_MEASURE;
            end
          end
          default: begin
            next_s.st = PFS_SEARCH;
          end
        endcase
      end else if (s.st[1] && s.cnt == s.interval) begin
        next_s.st = PFS_SEARCH;
      end else if (s.st == PFS_MEASURE && s.cnt == '1) begin
        next_s.st = PFS_SEARCH;
      end
    end
    next_s.locked = (next_s.st == PFS_LOCKED);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign frm.locked = s.locked;
endmodule // pfs_sync

`default_nettype wire

/* design/pfs_fifo.sv */
// Receive word FIFO with a registered output stage.
// Assumes DEPTH is a power of two; the sink may stall with ready low.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_cfg.svh"

module pfs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `PFS_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  pfs_stream_if.snk wr,
  pfs_stream_if.src rd
);
  import pfs_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic [W-1:0] out_data;
    logic out_valid;
  } pfs_fifo_state_t;

  pfs_fifo_state_t s;
  pfs_fifo_state_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = wr.valid && (s.cnt != FULL);
    pop = (!s.out_valid || rd.ready) && (s.cnt != '0);
    if (!s.out_valid || rd.ready) begin
      next_s.out_valid = pop;
    end
    if (pop) begin
      next_s.out_data = s.mem[s.rp];
      next_s.rp = s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = wr.data;
      next_s.wp = s.wp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wr.ready = (s.cnt != FULL);
  assign rd.data = s.out_data;
  assign rd.valid = s.out_valid;
endmodule // pfs_fifo

`default_nettype wire

/* testbench/pfs_port_monitor.sv */
// Checker bound to pfs_port; it watches the top module's ports only.
// Assumes CLK_I is the only clock and RESET_I is synchronous, active high.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_cfg.svh"

module pfs_port_monitor
  import pfs_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire pfs_pkg::pfs_mode_t MODE_I,
  input wire logic [`PFS_PORTS-1:0] TX_ENABLE_I,
  input wire logic PCM_FRAME_PULSE_I,
  input wire logic RX_READY_I,
  input wire logic [`PFS_PORTS-1:0] PCM_TX_LINE_OE_O,
  input wire logic [`PFS_PORTS-1:0] TX_DRIVE_INDICATOR_O,
  input wire logic TX_LOAD_O,
  input wire pfs_pkg::pfs_rx_word_t RX_DATA_O,
  input wire logic RX_VALID_O,
  input wire logic FRAME_LOCK_FLAG_O
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic pulse_q;
  logic [7:0] since_pulse;

  function automatic logic [3:0] act(input pfs_mode_t m);
    if (m == PFS_MODE_0) return `PFS_ACT_MODE0;
    if (m == PFS_MODE_1) return `PFS_ACT_MODE1;
    return `PFS_ACT_MODE2;
  endfunction

  // Saturates so a long gap never wraps into a false recent pulse
  always_ff @(posedge CLK_I) begin
    pulse_q <= PCM_FRAME_PULSE_I;
    if (RESET_I) since_pulse <= 8'hff;
    else if (PCM_FRAME_PULSE_I && !pulse_q) since_pulse <= 8'h00;
    else if (since_pulse != 8'hff) since_pulse <= since_pulse + 8'h01;
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  property p_ind_inv;
    TX_DRIVE_INDICATOR_O == ~PCM_TX_LINE_OE_O;
  endproperty
  a_ind_inv: assert property (p_ind_inv) else $error("indicator not inverse");

  property p_reset_out;
    disable iff (1'b0) RESET_I |=> TX_DRIVE_INDICATOR_O == 4'hf && !FRAME_LOCK_FLAG_O
      && !RX_VALID_O && !TX_LOAD_O;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not reset");

  property p_oe_locked;
    PCM_TX_LINE_OE_O != 4'h0 |->
      FRAME_LOCK_FLAG_O || $past(FRAME_LOCK_FLAG_O) || $past(FRAME_LOCK_FLAG_O, 2);
  endproperty
  a_oe_locked: assert property (p_oe_locked) else $error("drive while unlocked");

  property p_oe_mode;
    (PCM_TX_LINE_OE_O & ~act($past(MODE_I)) & ~act(MODE_I)) == 4'h0;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("inactive lane driven");

  property p_oe_enable;
    (PCM_TX_LINE_OE_O & ~$past(PCM_TX_LINE_OE_O) & ~$past(TX_ENABLE_I)) == 4'h0;
  endproperty
  a_oe_enable: assert property (p_oe_enable) else $error("disabled lane driven");

  property p_load_gap;
    TX_LOAD_O |=> !TX_LOAD_O [*7];
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("loads too close");

  property p_lock_pulse;
    $rose(FRAME_LOCK_FLAG_O) |-> since_pulse <= 8'h14;
  endproperty
  a_lock_pulse: assert property (p_lock_pulse) else $error("lock without pulse");

  property p_rx_hold;
    RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word not held");
endmodule // pfs_port_monitor

bind pfs_port pfs_port_monitor i_pfs_port_monitor (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .MODE_I(MODE_I), .TX_ENABLE_I(TX_ENABLE_I),
  .PCM_FRAME_PULSE_I(PCM_FRAME_PULSE_I), .RX_READY_I(RX_READY_I),
  .PCM_TX_LINE_OE_O(PCM_TX_LINE_OE_O), .TX_DRIVE_INDICATOR_O(TX_DRIVE_INDICATOR_O),
  .TX_LOAD_O(TX_LOAD_O), .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O),
  .FRAME_LOCK_FLAG_O(FRAME_LOCK_FLAG_O)
);

`default_nettype wire

/* testbench/pfs_highway.sv */
// Behavioural PCM highway: bit clock, one-bit frame pulse, receive lanes.
// Assumes the bench sets the frame length before raising run_i.
`timescale 1ns/1ns
`default_nettype none

module pfs_highway (
  input wire logic run_i,
  input wire logic double_i,
  input wire logic [9:0] frame_bits_i,
  input wire logic [7:0] rx_base_i,
  output logic bit_clock_o,
  output logic frame_pulse_o,
  output logic [3:0] rx_line_o
);
  // ****************************************
  // Highway timing
  // ****************************************
  logic [9:0] bit_n;
  logic [7:0] lane_byte;
  int p;

  initial begin
    bit_clock_o = 1'b0;
    frame_pulse_o = 1'b0;
    rx_line_o = 4'h0;
    bit_n = 10'h000;
    // Odd start puts every bit clock edge 13 ns ahead of a CLK_I rising edge
    #37;
    forever begin
      #(double_i ? 200 : 400);
      if (run_i) begin
        bit_clock_o = 1'b0;
        frame_pulse_o = (bit_n == 10'h000);
        for (p = 0; p < 4; p++) begin
          lane_byte = (rx_base_i + 8'(bit_n[9:3])) ^ 8'(p);
          rx_line_o[p] = lane_byte[3'h7 - bit_n[2:0]];
        end
        #(double_i ? 200 : 400);
        if (double_i) begin
          // Double clocking: a whole extra clock cycle inside the same bit
          bit_clock_o = 1'b1;
          #200;
          bit_clock_o = 1'b0;
          #200;
        end
        bit_clock_o = 1'b1;
        bit_n = (bit_n + 10'h001 >= frame_bits_i) ? 10'h000 : bit_n + 10'h001;
      end else begin
        // Idle lanes flip so stale bits never look like fresh data
        frame_pulse_o = 1'b0;
        rx_line_o = ~rx_line_o;
      end
    end
  end
endmodule // pfs_highway

`default_nettype wire

/* testbench/pcm_frame_sync_port_tb.sv */
// Self-checking bench for the PCM frame sync port against a highway model.
// Assumes the design files, the checker and pfs_highway compile before it.
`timescale 1ns/1ns
`default_nettype none

module pcm_frame_sync_port_tb;
  import pfs_pkg::*;
  // ****************************************
  // Bench
  // ****************************************
  logic clk, rst, rx_ready, run, bit_clock, frame_pulse, tx_load, rx_valid;
  logic rx_overrun, lock_flag, gci_clk, gci_sync, dbl;
  pfs_mode_t mode;
  logic [9:0] in_ofs, out_ofs, third_ofs, frame_bits;
  logic [3:0] tx_en, rx_line, tx_line, tx_oe, drive_ind;
  logic [6:0] tx_slot;
  pfs_lanes_t tx_data;
  pfs_rx_word_t rx_data;
  int mismatches = 0;
  int n_compared = 0;

  pfs_highway i_pfs_highway (.run_i(run), .double_i(dbl), .frame_bits_i(frame_bits),
    .rx_base_i(8'ha5),
    .bit_clock_o(bit_clock), .frame_pulse_o(frame_pulse), .rx_line_o(rx_line));
  pfs_port i_pfs_port (.CLK_I(clk), .RESET_I(rst), .MODE_I(mode), .DOUBLE_CLOCK_I(dbl),
    .INPUT_FRAME_OFFSET_I(in_ofs), .OUTPUT_FRAME_OFFSET_I(out_ofs),
    .THIRD_FRAME_OFFSET_I(third_ofs), .TX_ENABLE_I(tx_en), .TX_DATA_I(tx_data),
    .PCM_BIT_CLOCK_I(bit_clock), .PCM_FRAME_PULSE_I(frame_pulse),
    .PCM_RX_LINE_I(rx_line), .RX_READY_I(rx_ready), .PCM_TX_LINE_O(tx_line),
    .PCM_TX_LINE_OE_O(tx_oe), .TX_DRIVE_INDICATOR_O(drive_ind), .TX_SLOT_O(tx_slot),
    .TX_LOAD_O(tx_load), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .RX_OVERRUN_O(rx_overrun), .FRAME_LOCK_FLAG_O(lock_flag),
    .GCI_BIT_CLOCK_OUT_O(gci_clk), .GCI_FRAME_SYNC_OUT_O(gci_sync));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_flag(input logic want, output int n);
    for (n = 0; n < 2000 && lock_flag !== want; n++) @(negedge clk);
  endtask

  task automatic t_reset;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    check(drive_ind, 4'hf);
    check({lock_flag, rx_valid, tx_oe}, 6'h00);
    rst = 1'b0;
    $display("t_reset done");
  endtask

  task automatic t_lock;
    int n;
    frame_bits = 10'h020;
    run = 1'b1;
    wait_flag(1'b1, n);
    check(n >= 400, 1'b1);
    check(lock_flag, 1'b1);
    frame_bits = 10'h028;
    wait_flag(1'b0, n);
    check(lock_flag, 1'b0);
    check(n < 400, 1'b1);
    wait_flag(1'b1, n);
    check(lock_flag, 1'b1);
    frame_bits = 10'h020;
    wait_flag(1'b0, n);
    wait_flag(1'b1, n);
    $display("t_lock done");
  endtask

  task automatic rx_expect(input logic [9:0] ofs, input logic [31:0] exp);
    int n;
    in_ofs = ofs;
    repeat (600) @(negedge clk);
    for (n = 0; n < 400 && !(rx_valid === 1'b1 && rx_data.slot === 7'h00); n++) @(negedge clk);
    check(rx_data.lanes, exp);
  endtask

  task automatic t_rx;
    rx_expect(10'h000, 32'ha6a7a4a5);
    rx_expect(10'h004, 32'h6a7a4a5a);
    rx_expect(10'h008, 32'ha5a4a7a6);
    mode = PFS_MODE_2;
    rx_expect(10'h000, 32'h000000a5);
    mode = PFS_MODE_0;
    $display("t_rx done");
  endtask

  // The stall outlasts depth plus staging, so the buffer must refuse
  task automatic t_stall;
    int n;
    check(rx_overrun, 1'b0);
    rx_ready = 1'b0;
    repeat (1000) @(negedge clk);
    check({rx_valid, rx_overrun}, 2'h3);
    rx_ready = 1'b1;
    for (n = 0; n < 60 && rx_valid !== 1'b0; n++) @(negedge clk);
    check({rx_valid, rx_overrun}, 2'h1);
    $display("t_stall done");
  endtask

  task automatic t_tx;
    int n, b, p;
    pfs_lanes_t got;
    logic [6:0] sl;
    tx_data = {8'h96, 8'h5a, 8'h3c, 8'hc3};
    tx_en = 4'hf;
    repeat (100) @(negedge clk);
    for (n = 0; n < 200 && tx_load !== 1'b1; n++) @(negedge clk);
    sl = tx_slot;
    check({tx_oe, drive_ind}, 8'hf0);
    repeat (4) @(negedge clk);
    for (b = 7; b >= 0; b--) begin
      for (p = 0; p < 4; p++) got[p][b] = tx_line[p];
      repeat (8) @(negedge clk);
    end
    check(got, tx_data);
    check(tx_slot, (sl + 7'h01) & 7'h03);
    mode = PFS_MODE_2;
    repeat (100) @(negedge clk);
    check(tx_oe, 4'h1);
    mode = PFS_MODE_0;
    tx_en = 4'h5;
    repeat (100) @(negedge clk);
    check(drive_ind, 4'ha);
    $display("t_tx done");
  endtask

  task automatic gci_count(output int n_clk, output int n_sync);
    int k;
    logic pc, ps;
    n_clk = 0;
    n_sync = 0;
    repeat (300) @(negedge clk);
    for (k = 0; k < 256; k++) begin
      pc = gci_clk;
      ps = gci_sync;
      @(negedge clk);
      n_clk += (gci_clk === 1'b1 && pc === 1'b0);
      n_sync += (gci_sync === 1'b1 && ps === 1'b0);
    end
  endtask

  task automatic t_gci;
    int n_clk, n_sync;
    third_ofs = 10'h004;
    gci_count(n_clk, n_sync);
    check(n_clk, 32);
    check(n_sync, 1);
    $display("t_gci done");
  endtask

  // Switched under reset so the port never sees a half-changed clock
  task automatic t_double;
    int n, n_clk, n_sync;
    dbl = 1'b1;
    mode = PFS_MODE_1;
    t_reset;
    wait_flag(1'b1, n);
    check(lock_flag, 1'b1);
    rx_expect(10'h000, 32'h0000a4a5);
    gci_count(n_clk, n_sync);
    check(n_clk, 32);
    check(n_sync, 1);
    $display("t_double done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Full run is near 10000 cycles; the limit leaves ample margin
  initial begin
    #3000000;
    mismatches++;
    test_done;
  end

  initial begin
    int n;
    rst = 1'b1;
    mode = PFS_MODE_0;
    {in_ofs, out_ofs, third_ofs} = 30'h0;
    tx_en = 4'h0;
    tx_data = '0;
    rx_ready = 1'b1;
    run = 1'b0;
    dbl = 1'b0;
    frame_bits = 10'h020;
    t_reset;
    t_lock;
    t_rx;
    t_stall;
    t_tx;
    t_gci;
    t_double;
    t_reset;
    wait_flag(1'b1, n);
    check(lock_flag, 1'b1);
    test_done;
  end
endmodule // pcm_frame_sync_port_tb

`default_nettype wire
